// ===== sensor_seq_pkg.sv
`default_nettype none
package sensor_seq_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int SYS_CLK_MHZ = 100;
    localparam real INIT_US = 400.0;
    localparam real RECAL_US = 100.0;
    localparam real CONV_T_MS [6] = '{65.6, 32.8, 16.4, 8.2, 4.1, 2.1};
    localparam real CONV_TP_MS [6] = '{131.1, 65.6, 32.8, 16.4, 8.2, 4.1};

    function automatic int unsigned us_to_cyc(real us);
        return $rtoi(us * SYS_CLK_MHZ + 0.5);
    endfunction : us_to_cyc

    localparam int unsigned INIT_CYC_DEF = us_to_cyc(INIT_US);
    localparam int unsigned RECAL_CYC_DEF = us_to_cyc(RECAL_US);
    localparam int unsigned CONV_T_CYC_DEF [6] = '{
        us_to_cyc(CONV_T_MS[0] * 1000.0), us_to_cyc(CONV_T_MS[1] * 1000.0),
        us_to_cyc(CONV_T_MS[2] * 1000.0), us_to_cyc(CONV_T_MS[3] * 1000.0),
        us_to_cyc(CONV_T_MS[4] * 1000.0), us_to_cyc(CONV_T_MS[5] * 1000.0)};
    localparam int unsigned CONV_TP_CYC_DEF [6] = '{
        us_to_cyc(CONV_TP_MS[0] * 1000.0), us_to_cyc(CONV_TP_MS[1] * 1000.0),
        us_to_cyc(CONV_TP_MS[2] * 1000.0), us_to_cyc(CONV_TP_MS[3] * 1000.0),
        us_to_cyc(CONV_TP_MS[4] * 1000.0), us_to_cyc(CONV_TP_MS[5] * 1000.0)};
    localparam int CNT_W = 24;

    // ----------------------------------------------------------------
    // command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_SOFT_RST = 8'h06;
    localparam logic [7:0] CMD_RD_TP = 8'h10;
    localparam logic [7:0] CMD_RD_TA = 8'h11;
    localparam logic [7:0] CMD_RD_P = 8'h30;
    localparam logic [7:0] CMD_RD_A = 8'h31;
    localparam logic [7:0] CMD_RD_T = 8'h32;
    localparam logic [7:0] CMD_RECAL = 8'h28;
    localparam logic [2:0] CONVERT_CMD_PREFIX = 3'h2;
    localparam logic [1:0] REG_RD_PREFIX = 2'h2;
    localparam logic [1:0] REG_WR_PREFIX = 2'h3;
    localparam logic [1:0] CHNL_TP = 2'h0;
    localparam logic [1:0] CHNL_T = 2'h2;
    localparam logic [2:0] RATIO_MAX_CODE = 3'h5;

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    localparam logic [5:0] EVENT_SRC_ADDR = 6'h0d;
    localparam logic [5:0] COMP_SEL_ADDR = 6'h0f;
    localparam int EV_DEV_RDY_BIT = 6;
    localparam int EV_CONV_DONE_BIT = 5;
    localparam int EV_CONV_FAIL_BIT = 4;
    localparam int COMP_EN_BIT = 0;
    localparam logic [7:0] COMP_SEL_RST = 8'h01;

    // ----------------------------------------------------------------
    // result storage
    // ----------------------------------------------------------------
    localparam int RES_W = 24;
    localparam int N_WORDS = 3;
    localparam logic [1:0] WORD_T = 2'h0;
    localparam logic [1:0] WORD_P = 2'h1;
    localparam logic [1:0] WORD_A = 2'h2;
    localparam logic [2:0] BYTES_ONE_WORD = 3'h3;
    localparam logic [2:0] BYTES_TWO_WORDS = 3'h6;
    localparam logic [2:0] BYTES_REG = 3'h1;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_BOOT, ST_INIT, ST_SLEEP, ST_CONV_T, ST_CONV_P, ST_RECAL
    } seq_state_t;

    typedef struct packed {
        logic clk;
        logic wr_valid;
        logic wr_first;
        logic rd_ack;
        logic [7:0] wr_byte;
    } link_in_t;

    typedef struct packed {
        link_in_t s1;
        link_in_t s2;
        logic clk3;
        seq_state_t st;
        logic [CNT_W-1:0] cnt;
        logic dev_rdy;
        logic conv_done;
        logic conv_fail;
        logic [7:0] comp_sel;
        logic [2:0] ratio;
        logic both;
        logic comp;
        logic pend_wr;
        logic [5:0] pend_addr;
        logic rd_reg;
        logic [7:0] reg_byte;
        logic [1:0] w0;
        logic [1:0] w1;
        logic [2:0] nbytes;
        logic [2:0] idx;
        logic [7:0] tx;
        logic adc_run;
        logic cal_run;
        logic press_sel;
    } seq_reg_t;

    localparam seq_reg_t SEQ_RST = '{st: ST_BOOT, comp_sel: COMP_SEL_RST, default: '0};

    typedef struct packed {
        logic [N_WORDS-1:0][RES_W-1:0] mem;
        logic [RES_W-1:0] rd;
    } store_t;

endpackage : sensor_seq_pkg
`default_nettype wire

// ===== result_store.sv
`timescale 1ns/1ps
`default_nettype none
module result_store
    import sensor_seq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clr,
    input wire logic [N_WORDS-1:0] we,
    input wire logic [N_WORDS-1:0][RES_W-1:0] wdata,
    input wire logic [1:0] raddr,
    output logic [RES_W-1:0] rdata
);

    // ----------------------------------------------------------------
    // storage, kept through sleep, cleared by reset or by clr
    // ----------------------------------------------------------------
    store_t q;
    store_t d;

    // per-entry write, registered read
    always_comb begin
        d = q;
        d.rd = (raddr < 2'(N_WORDS)) ? q.mem[raddr] : '0;
        for (int i = 0; i < N_WORDS; i++) begin
            if (we[i]) begin
                d.mem[i] = wdata[i];
            end
        end
        if (clr) begin
            d.mem = '0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rdata = q.rd;

endmodule : result_store
`default_nettype wire

// ===== sensor_cmd_seq.sv
// Contract
// - run init after reset, then sleep
// - set ready flag when init completes
// - sleep until command, return after job
// - pressure job converts temperature first
// - results kept in storage across sleep
// - conversion time follows the ratio table
// - honour compensation select at conversion start
// - calibrate exactly once per reset cycle; the code also recalibrates on each 0x28 received in sleep
// - code 0x06 resets at once
// - soft reset clears storage, reruns init
// - convert byte is 010, ratio, channel
// - channel 00 both, 10 temperature only
// - ratio codes 000 to 101 select rates
// - bad channel or ratio fails conversion
// - 0x10 returns temperature then pressure
// - 0x11 returns temperature then altitude
// - 0x30 returns pressure, three bytes
// - 0x31 returns altitude, three bytes
// - 0x32 returns temperature, three bytes
// - 0x28 recalibrates briefly, then sleeps
// - 10 reads, 11 writes a register
// - register address in low six bits
// - register write carries one data byte
// - one byte on register read, three or six on result read
`timescale 1ns/1ps
`default_nettype none
module sensor_cmd_seq
    import sensor_seq_pkg::*;
#(
    parameter int unsigned INIT_CYC = INIT_CYC_DEF,
    parameter int unsigned RECAL_CYC = RECAL_CYC_DEF,
    parameter int unsigned CONV_T_CYC [6] = CONV_T_CYC_DEF,
    parameter int unsigned CONV_TP_CYC [6] = CONV_TP_CYC_DEF
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire link_in_t link_in,
    input wire logic [RES_W-1:0] adc_temp,
    input wire logic [RES_W-1:0] adc_press,
    input wire logic [RES_W-1:0] adc_alt,
    output logic [7:0] link_rd_byte,
    output logic dev_ready,
    output logic conv_fail,
    output logic adc_run,
    output logic cal_run,
    output logic adc_press_sel,
    output logic [2:0] adc_ratio,
    output logic adc_comp
);

    // ----------------------------------------------------------------
    // state and storage
    // ----------------------------------------------------------------
    seq_reg_t q;
    seq_reg_t d;
    logic mem_clr;
    logic [N_WORDS-1:0] mem_we;
    logic [N_WORDS-1:0][RES_W-1:0] mem_wdata;
    logic [1:0] mem_raddr;
    logic [RES_W-1:0] mem_rdata;
    logic ev;
    logic wr_ev;
    logic cmd_ev;
    logic [7:0] wb;
    logic [1:0] pos;

    // link edge found from the synchronised clock
    assign ev = q.s2.clk & ~q.clk3;
    assign wr_ev = ev & q.s2.wr_valid;
    assign cmd_ev = wr_ev & q.s2.wr_first;
    assign wb = q.s2.wr_byte;

    // results in hundredths, two's complement, straight from the front end
    assign mem_wdata[WORD_T] = adc_temp;
    assign mem_wdata[WORD_P] = adc_press;
    assign mem_wdata[WORD_A] = adc_alt;

    // current word and byte within it
    assign mem_raddr = (q.idx < BYTES_ONE_WORD) ? q.w0 : q.w1;
    assign pos = (q.idx < BYTES_ONE_WORD) ? q.idx[1:0] : 2'(q.idx - BYTES_ONE_WORD);

    // results retained in sleep, wiped by soft reset
    result_store u_store (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clr(mem_clr),
        .we(mem_we),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    // ----------------------------------------------------------------
    // sequencer and command decoder
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        mem_we = '0;
        mem_clr = 1'b0;
        d.s1 = link_in;
        d.s2 = q.s1;
        d.clk3 = q.s2.clk;
        d.cnt = (q.cnt != '0) ? q.cnt - 1'b1 : '0;

        // job timing
        unique case (q.st)
            ST_BOOT: begin
                d.st = ST_INIT;
                d.cnt = CNT_W'(INIT_CYC - 1);
                d.cal_run = 1'b1;
            end
            ST_INIT: begin
                if (q.cnt == '0) begin
                    d.st = ST_SLEEP;
                    d.dev_rdy = 1'b1;
                    d.cal_run = 1'b0;
                end
            end
            ST_SLEEP: begin
            end
            ST_CONV_T: begin
                if (q.cnt == '0) begin
                    mem_we[WORD_T] = 1'b1;
                    if (q.both) begin
                        d.st = ST_CONV_P;
                        d.press_sel = 1'b1;
                        d.cnt = CNT_W'(CONV_TP_CYC[q.ratio] - CONV_T_CYC[q.ratio] - 1);
                    end else begin
                        d.st = ST_SLEEP;
                        d.adc_run = 1'b0;
                        d.conv_done = 1'b1;
                    end
                end
            end
            ST_CONV_P: begin
                if (q.cnt == '0) begin
                    mem_we[WORD_P] = 1'b1;
                    mem_we[WORD_A] = 1'b1;
                    d.st = ST_SLEEP;
                    d.adc_run = 1'b0;
                    d.press_sel = 1'b0;
                    d.conv_done = 1'b1;
                end
            end
            ST_RECAL: begin
                if (q.cnt == '0) begin
                    d.st = ST_SLEEP;
                    d.cal_run = 1'b0;
                end
            end
        endcase

        // read pointer advances on each acknowledged byte
        if (ev && q.s2.rd_ack && q.idx != q.nbytes) begin
            d.idx = q.idx + 1'b1;
        end

        // byte presented to the link
        if (q.idx >= q.nbytes) begin
            d.tx = 8'h00;
        end else if (q.rd_reg) begin
            d.tx = q.reg_byte;
        end else begin
            unique case (pos)
                2'h0: d.tx = mem_rdata[23:16];
                2'h1: d.tx = mem_rdata[15:8];
                default: d.tx = mem_rdata[7:0];
            endcase
        end

        // incoming bytes
        if (cmd_ev) begin
            d.pend_wr = 1'b0;
            if (wb == CMD_SOFT_RST) begin
                d = SEQ_RST;
                d.s1 = link_in;
                d.s2 = q.s1;
                d.clk3 = q.s2.clk;
                mem_clr = 1'b1;
            end else if (wb[7:6] == REG_WR_PREFIX) begin
                d.pend_wr = 1'b1;
                d.pend_addr = wb[5:0];
            end else if (wb[7:6] == REG_RD_PREFIX) begin
                d.rd_reg = 1'b1;
                d.idx = '0;
                d.nbytes = BYTES_REG;
                d.reg_byte = '0;
                if (wb[5:0] == EVENT_SRC_ADDR) begin
                    d.reg_byte[EV_DEV_RDY_BIT] = q.dev_rdy;
                    d.reg_byte[EV_CONV_DONE_BIT] = q.conv_done;
                    d.reg_byte[EV_CONV_FAIL_BIT] = q.conv_fail;
                end else if (wb[5:0] == COMP_SEL_ADDR) begin
                    d.reg_byte = q.comp_sel;
                end
            end else if (wb[7:5] == CONVERT_CMD_PREFIX) begin
                if (q.st == ST_SLEEP) begin
                    d.conv_done = 1'b0;
                    if ((wb[1:0] != CHNL_TP && wb[1:0] != CHNL_T)
                            || wb[4:2] > RATIO_MAX_CODE) begin
                        d.conv_fail = 1'b1;
                    end else begin
                        d.conv_fail = 1'b0;
                        d.st = ST_CONV_T;
                        d.ratio = wb[4:2];
                        d.both = (wb[1:0] == CHNL_TP);
                        d.comp = q.comp_sel[COMP_EN_BIT];
                        d.cnt = CNT_W'(CONV_T_CYC[wb[4:2]] - 1);
                        d.adc_run = 1'b1;
                        d.press_sel = 1'b0;
                    end
                end
            end else if (wb == CMD_RECAL) begin
                if (q.st == ST_SLEEP) begin
                    d.st = ST_RECAL;
                    d.cnt = CNT_W'(RECAL_CYC - 1);
                    d.cal_run = 1'b1;
                end
            end else begin
                // result reads, word order and length
                d.rd_reg = 1'b0;
                d.idx = '0;
                unique case (wb)
                    CMD_RD_TP: begin
                        d.w0 = WORD_T;
                        d.w1 = WORD_P;
                        d.nbytes = BYTES_TWO_WORDS;
                    end
                    CMD_RD_TA: begin
                        d.w0 = WORD_T;
                        d.w1 = WORD_A;
                        d.nbytes = BYTES_TWO_WORDS;
                    end
                    CMD_RD_P: begin
                        d.w0 = WORD_P;
                        d.nbytes = BYTES_ONE_WORD;
                    end
                    CMD_RD_A: begin
                        d.w0 = WORD_A;
                        d.nbytes = BYTES_ONE_WORD;
                    end
                    CMD_RD_T: begin
                        d.w0 = WORD_T;
                        d.nbytes = BYTES_ONE_WORD;
                    end
                    default: begin
                        d.rd_reg = q.rd_reg;
                        d.idx = q.idx;
                    end
                endcase
            end
        end else if (wr_ev && q.pend_wr) begin
            d.pend_wr = 1'b0;
            if (q.pend_addr == COMP_SEL_ADDR) begin
                d.comp_sel = wb;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= SEQ_RST;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign link_rd_byte = q.tx;
    assign dev_ready = q.dev_rdy;
    assign conv_fail = q.conv_fail;
    assign adc_run = q.adc_run;
    assign cal_run = q.cal_run;
    assign adc_press_sel = q.press_sel;
    assign adc_ratio = q.ratio;
    assign adc_comp = q.comp;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_cmd(logic [7:0] code);
        cmd_ev && wb == code;
    endsequence

    sequence s_comp_write;
        wr_ev && !q.s2.wr_first && q.pend_wr && q.pend_addr == COMP_SEL_ADDR;
    endsequence

    AST_INIT_TO_READY: assert property (
        (q.st == ST_INIT && q.cnt == '0 && !cmd_ev) |=> (q.st == ST_SLEEP && dev_ready)
    ) else $error("init did not end in sleep with ready set");

    AST_READY_HELD: assert property (
        (q.st == ST_INIT) |-> !dev_ready
    ) else $error("ready flag set during init");

    AST_SOFT_RESET: assert property (
        s_cmd(CMD_SOFT_RST) |=> (q.st == ST_BOOT && !dev_ready && !adc_run)
            ##1 (q.st == ST_INIT && cal_run)
    ) else $error("soft reset did not restart init");

    AST_TEMP_FIRST: assert property (
        $rose(q.st == ST_CONV_P) |-> ($past(q.st) == ST_CONV_T && adc_press_sel)
    ) else $error("pressure phase not preceded by temperature");

    AST_BAD_CONVERT: assert property (
        (cmd_ev && wb[7:5] == CONVERT_CMD_PREFIX && q.st == ST_SLEEP && wb[4:3] == 2'h3)
            |=> (conv_fail && q.st == ST_SLEEP && !adc_run)
    ) else $error("invalid ratio did not fail");

    AST_CONV_START: assert property (
        (cmd_ev && wb == 8'h56 && q.st == ST_SLEEP)
            |=> (q.st == ST_CONV_T && q.cnt == CNT_W'(CONV_T_CYC[5] - 1) && adc_ratio == 3'h5)
    ) else $error("conversion start count wrong");

    AST_COMP_TAKEN: assert property (
        $rose(adc_run) |-> (adc_comp == $past(q.comp_sel[COMP_EN_BIT]))
    ) else $error("compensation select not honoured");

    AST_RECAL_SLEEP: assert property (
        (q.st == ST_RECAL && q.cnt == '0 && !cmd_ev) |=> (q.st == ST_SLEEP && !cal_run)
    ) else $error("recalibration did not return to sleep");

    AST_REG_WRITE: assert property (
        s_comp_write |=> (q.comp_sel == $past(wb))
    ) else $error("register write lost");

    AST_CAL_ONCE: assert property (
        q.dev_rdy |=> (q.st != ST_INIT)
    ) else $error("second calibration in one reset cycle");

endmodule : sensor_cmd_seq
`default_nettype wire

// ===== link_host.sv
`timescale 1ns/1ps
`default_nettype none
module link_host
    import sensor_seq_pkg::*;
(
    input wire logic sys_clk,
    output var link_in_t link_in
);
    // ----------------------------------------------------------------
    // host side of the link
    // ----------------------------------------------------------------

    // link idle, clock low
    initial begin
        link_in = '0;
    end

    // one link clock period of 90 ns, lines held around the rise
    task automatic pulse(input logic v, input logic f, input logic a, input logic [7:0] b);
        begin
            @(negedge sys_clk);
            link_in.wr_valid = v;
            link_in.wr_first = f;
            link_in.rd_ack = a;
            link_in.wr_byte = b;
            repeat (4) @(negedge sys_clk);
            link_in.clk = 1'b1;
            repeat (4) @(negedge sys_clk);
            link_in.clk = 1'b0;
            link_in.wr_valid = 1'b0;
            link_in.wr_first = 1'b0;
            link_in.rd_ack = 1'b0;
            link_in.wr_byte = ~b; // released lines show the inverse
        end
    endtask : pulse

    // one written byte
    task automatic send(input logic f, input logic [7:0] b);
        pulse(1'b1, f, 1'b0, b);
    endtask : send

    // consume the current read byte
    task automatic ack();
        pulse(1'b0, 1'b0, 1'b1, ~link_in.wr_byte);
    endtask : ack

    // command byte builders
    function automatic logic [7:0] cvt(input logic [2:0] r, input logic [1:0] c);
        return {CONVERT_CMD_PREFIX, r, c};
    endfunction : cvt

    function automatic logic [7:0] reg_rd(input logic [5:0] a);
        return {REG_RD_PREFIX, a};
    endfunction : reg_rd

    // command then one data byte
    task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
        begin
            send(1'b1, {REG_WR_PREFIX, a});
            send(1'b0, d);
        end
    endtask : wr_reg
endmodule : link_host
`default_nettype wire

// ===== pressure_sensor_command_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pressure_sensor_command_sequencer_tb_top
    import sensor_seq_pkg::*;
;
    // ----------------------------------------------------------------
    // shortened timing
    // ----------------------------------------------------------------
    localparam int unsigned T_CYC [6] = '{40, 32, 24, 16, 8, 4};
    localparam int unsigned TP_CYC [6] = '{80, 64, 48, 32, 16, 8};
    localparam int unsigned INIT_N = 20;
    localparam int unsigned RECAL_N = 10;

    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    link_in_t link_in;
    logic [RES_W-1:0] adc_temp = 24'h000a5c;
    logic [RES_W-1:0] adc_press = 24'h018a9e;
    logic [RES_W-1:0] adc_alt = 24'hffec78;
    logic [7:0] link_rd_byte;
    logic dev_ready, conv_fail, adc_run, cal_run, adc_press_sel, adc_comp, seen_comp;
    logic [2:0] adc_ratio;
    logic [2:0] seen_ratio;
    int fails = 0;
    int checks_done = 0;

    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    sensor_cmd_seq #(.INIT_CYC(INIT_N), .RECAL_CYC(RECAL_N), .CONV_T_CYC(T_CYC),
        .CONV_TP_CYC(TP_CYC)) u_sensor_cmd_seq (.sys_clk(sys_clk), .reset_n(reset_n),
        .link_in(link_in), .adc_temp(adc_temp), .adc_press(adc_press), .adc_alt(adc_alt),
        .link_rd_byte(link_rd_byte), .dev_ready(dev_ready), .conv_fail(conv_fail),
        .adc_run(adc_run), .cal_run(cal_run), .adc_press_sel(adc_press_sel),
        .adc_ratio(adc_ratio), .adc_comp(adc_comp));

    link_host u_link_host (.sys_clk(sys_clk), .link_in(link_in));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    // a used-up wait bound counts a mismatch and ends the run
    task automatic guard(input int k, input int lim);
        if (k >= lim) begin
            chk(k, 48'h0);
            report_and_stop();
        end
    endtask : guard

    // counts cycles of a job, split by phase
    task automatic measure(output int n_a, output int n_b);
        int k;
        n_a = 0;
        n_b = 0;
        for (k = 0; k < 400 && adc_run !== 1'b1 && cal_run !== 1'b1; k++)
            @(negedge sys_clk);
        guard(k, 400);
        seen_ratio = adc_ratio;
        seen_comp = adc_comp;
        while ((adc_run === 1'b1 || cal_run === 1'b1) && n_a + n_b < 400) begin
            if (adc_press_sel === 1'b1)
                n_b++;
            else
                n_a++;
            @(negedge sys_clk);
        end
        guard(n_a + n_b, 400);
    endtask : measure

    // read command then n bytes, each sampled before the next link edge
    task automatic rd_res(input logic [7:0] cmd, input int n, output logic [47:0] v);
        v = '0;
        u_link_host.send(1'b1, cmd);
        for (int i = 0; i < n; i++) begin
            repeat (4) @(negedge sys_clk);
            v = {v[39:0], link_rd_byte};
            u_link_host.ack();
        end
        repeat (4) @(negedge sys_clk);
        chk(link_rd_byte, 48'h0);
    endtask : rd_res

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_init;
        int n;
        logic [47:0] v;
        begin
            n = 0;
            while (dev_ready !== 1'b1 && n < 200) begin
                @(negedge sys_clk);
                n++;
                if (n == 1)
                    chk(cal_run, 48'h1);
            end
            guard(n, 200);
            chk(n, INIT_N + 1);
            chk(cal_run, 48'h0);
            repeat (30) @(negedge sys_clk);
            chk(cal_run, 48'h0);
            rd_res(u_link_host.reg_rd(EVENT_SRC_ADDR), 1, v);
            chk(v, 48'h40);
            $display("test done: power-up");
        end
    endtask : t_init

    task automatic t_fail;
        logic [7:0] bad [4];
        begin
            bad = '{u_link_host.cvt(3'h6, CHNL_TP), u_link_host.cvt(3'h7, CHNL_T),
                u_link_host.cvt(3'h0, 2'h1), u_link_host.cvt(3'h0, 2'h3)};
            foreach (bad[i]) begin
                u_link_host.send(1'b1, bad[i]);
                repeat (2) @(negedge sys_clk);
                chk(conv_fail, 48'h1);
                chk(adc_run, 48'h0);
            end
            $display("test done: bad conversions");
        end
    endtask : t_fail

    task automatic t_conv;
        int a, b;
        begin
            for (int r = 0; r < 6; r++) begin
                for (int c = 0; c < 2; c++) begin
                    fork
                        u_link_host.send(1'b1, u_link_host.cvt(r[2:0], c ? CHNL_T : CHNL_TP));
                        measure(a, b);
                    join
                    chk(a, T_CYC[r]);
                    chk(b, c ? 0 : TP_CYC[r] - T_CYC[r]);
                    chk(seen_ratio, r);
                    chk(conv_fail, 48'h0);
                end
            end
            $display("test done: conversion timing");
        end
    endtask : t_conv

    task automatic t_reads;
        logic [7:0] cmds [5];
        logic [47:0] exp [5];
        logic [47:0] v;
        int a, b;
        begin
            cmds = '{CMD_RD_TP, CMD_RD_TA, CMD_RD_P, CMD_RD_A, CMD_RD_T};
            exp = '{{adc_temp, adc_press}, {adc_temp, adc_alt}, {24'h0, adc_press},
                {24'h0, adc_alt}, {24'h0, adc_temp}};
            fork
                u_link_host.send(1'b1, u_link_host.cvt(3'h5, CHNL_TP));
                measure(a, b);
            join
            foreach (cmds[i]) begin
                rd_res(cmds[i], i < 2 ? 6 : 3, v);
                chk(v, exp[i]);
            end
            adc_temp = 24'h123456;
            repeat (40) @(negedge sys_clk);
            rd_res(CMD_RD_T, 3, v);
            chk(v, exp[4]);
            $display("test done: result reads");
        end
    endtask : t_reads

    task automatic t_reg;
        logic [47:0] v;
        int a, b;
        begin
            rd_res(u_link_host.reg_rd(COMP_SEL_ADDR), 1, v);
            chk(v, COMP_SEL_RST);
            for (int m = 0; m < 2; m++) begin
                u_link_host.wr_reg(COMP_SEL_ADDR, {7'h0, m[0]});
                rd_res(u_link_host.reg_rd(COMP_SEL_ADDR), 1, v);
                chk(v, m);
                fork
                    u_link_host.send(1'b1, u_link_host.cvt(3'h5, CHNL_T));
                    measure(a, b);
                join
                chk(seen_comp, m);
            end
            rd_res(u_link_host.reg_rd(6'h3f), 1, v);
            chk(v, 48'h0);
            $display("test done: registers");
        end
    endtask : t_reg

    task automatic t_recal;
        int a, b;
        begin
            fork
                u_link_host.send(1'b1, CMD_RECAL);
                measure(a, b);
            join
            chk(a, RECAL_N);
            chk(a < INIT_N, 48'h1);
            fork
                u_link_host.send(1'b1, u_link_host.cvt(3'h5, CHNL_T));
                measure(a, b);
            join
            chk(a, T_CYC[5]);
            $display("test done: recalibration");
        end
    endtask : t_recal

    task automatic t_soft;
        logic [47:0] v;
        int a, b, k;
        begin
            u_link_host.wr_reg(COMP_SEL_ADDR, 8'h00);
            u_link_host.send(1'b1, u_link_host.cvt(3'h0, CHNL_TP));
            chk(adc_run, 48'h1);
            fork
                u_link_host.send(1'b1, CMD_SOFT_RST);
                begin
                    for (k = 0; k < 12 && adc_run !== 1'b0; k++)
                        @(negedge sys_clk);
                    guard(k, 12);
                    chk(adc_run, 48'h0);
                    chk(dev_ready, 48'h0);
                    measure(a, b);
                end
            join
            chk(a, INIT_N);
            chk(dev_ready, 48'h1);
            rd_res(CMD_RD_TP, 6, v);
            chk(v, 48'h0);
            rd_res(u_link_host.reg_rd(COMP_SEL_ADDR), 1, v);
            chk(v, COMP_SEL_RST);
            $display("test done: soft reset");
        end
    endtask : t_soft

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(negedge sys_clk);
        reset_n = 1'b1;
        t_init();
        t_fail();
        t_conv();
        t_reads();
        t_reg();
        t_recal();
        t_soft();
        report_and_stop();
    end
endmodule : pressure_sensor_command_sequencer_tb_top
`default_nettype wire
